// file: src/irq_status_map.vh
// Register offsets, field positions and reset values for the interrupt status block
`ifndef IRQ_STATUS_MAP_VH
`define IRQ_STATUS_MAP_VH
`define ADDR_W 16
`define OFF_PENDING_LOW 16'hFE04
`define OFF_PENDING_MID 16'hFE05
`define OFF_PENDING_HIGH 16'hFE06
// Enable register, one bit per source event
`define OFF_ENABLE_LO 16'hFE08
`define OFF_ENABLE_HI 16'hFE09
// Sticky source flags, write one to clear
`define OFF_FLAGS_LO 16'hFE0A
`define OFF_FLAGS_HI 16'hFE0B
// Control: bit0 select conflict detect, bit1 conversion service select
`define OFF_CONTROL 16'hFE0C
// Timebase: bits 2..0 rate, bit 3 acknowledge (write one)
`define OFF_TICK 16'hFE0D
`define CTL_DETECT_BIT 0
`define CTL_SELECT_BIT 1
`define TICK_ACK_BIT 3
`define NUM_EV 16
`define EV_ROLL 0
`define EV_CH0 1
`define EV_SRX 2
`define EV_STX 3
`define EV_SELECT_CONFLICT_FLAG 4
`define EV_SOVR 5
`define EV_UTX 6
`define EV_TC 7
`define EV_URX 8
`define EV_IDLE 9
`define EV_UOVR 10
`define EV_NOISE 11
`define EV_FRAME 12
`define EV_PAR 13
`define EV_CONV 14
`define EV_TICK 15
`define IDLE_BITS 10
`define IDLE_BITS_LONG 11
`define RESET_BYTE 8'h00
`endif

// file: src/interrupt_source_status.v
// Interrupt source flags, enables and pending status registers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "irq_status_map.vh"

// What this block does
// [RULE1] Timer rollover after modulo match sets rollover flag, gated by enable
// [RULE2] Channel zero capture or compare sets its flag, gated by enable
// [RULE3] Serial byte into receive register sets receive-full, gated by enable
// [RULE4] Serial byte into shift register sets transmit-empty, gated by enable
// [RULE5] Select conflict flag: slave select rise in slave, low in master
// [RULE6] Serial overflow when new byte arrives before previous read
// [RULE7] Uart data handed to shifter sets transmit-empty, gated by enable
// [RULE8] Both transmit stages empty, no break or idle, sets complete
// [RULE9] Uart character into data register sets receive-full, gated
// [RULE10] Idle flag after 10 or 11 consecutive high receive bits
// [RULE11] Uart overrun on new character before previous read
// [RULE12] Noise detected in any bit sets noise flag
// [RULE13] Low level at stop bit sets framing flag
// [RULE14] Parity check failure sets parity flag
// [RULE15] Low on any keyboard input latches an external request
// [RULE16] Converter requests after every conversion when its enable is set and service select is clear
// [RULE17] Timebase rollover sets tick flag at selected rate, gated by enable
// [RULE18] Software clears tick flag by writing one to acknowledge
// [RULE19] Sixteen numbered pending flags, one while request present
// [RULE20] First status register: flags 6..1 in bits 7..2, low bits zero
// [RULE21] Second status register: flags 14..7 in bits 7..0
// [RULE22] Third status register: flag 16 bit 1, flag 15 bit 0
// [RULE23] Highest priority pending request, lowest number, offered first
// [RULE24] Status flag is OR of source flags ANDed with enables
module interrupt_source_status (
  input wire sys_clk,
  input wire reset_n,
  input wire [`ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  input wire ext_irq_req,
  input wire pll_irq_req,
  input wire [2:0] timer1_irq_req,
  input wire timer2_rollover,
  input wire timer2_chan0_event,
  input wire spi_rx_load,
  input wire spi_tx_load,
  input wire spi_is_master,
  input wire spi_busy,
  input wire spi_select_n,
  input wire spi_data_read,
  input wire uart_tx_load,
  input wire uart_shift_empty,
  input wire uart_data_empty,
  input wire uart_break_idle_gen,
  input wire uart_rx_load,
  input wire uart_rx_bit_valid,
  input wire uart_rx_bit,
  input wire uart_long_frame,
  input wire uart_data_read,
  input wire uart_noise,
  input wire uart_stop_sample,
  input wire uart_stop_bit,
  input wire uart_parity_fail,
  input wire [4:0] kbd_pins_n,
  input wire kbd_ack,
  input wire conv_done,
  input wire tick_rollover,
  output reg [2:0] tick_rate_select,
  output reg [4:0] irq_vector_num,
  output reg irq_pending
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
// Select and keyboard pins arrive from outside, so two stages first
reg [5:0] pin_meta_q;
reg [5:0] pin_sync_q;
reg select_prev_q;
always @(posedge sys_clk)
begin
  if (!reset_n)
  begin
    pin_meta_q <= 6'h3F;
    pin_sync_q <= 6'h3F;
    select_prev_q <= 1'b1;
  end
  else
  begin
    pin_meta_q <= {kbd_pins_n, spi_select_n};
    pin_sync_q <= pin_meta_q;
    select_prev_q <= pin_sync_q[0];
  end
end
wire select_n = pin_sync_q[0];

// ----------------------------------------------------------------
// Registers written by software
// ----------------------------------------------------------------
reg [`NUM_EV-1:0] enable_q;
reg detect_en_q;
reg service_sel_q;
reg [`NUM_EV-1:0] flags_q;
reg kbd_latch_q;
reg [3:0] idle_cnt_q;
reg spi_unread_q;
reg uart_unread_q;
wire wr_hit_en_lo = wr_stb && addr == `OFF_ENABLE_LO;
wire wr_hit_en_hi = wr_stb && addr == `OFF_ENABLE_HI;
wire wr_hit_fl_lo = wr_stb && addr == `OFF_FLAGS_LO;
wire wr_hit_fl_hi = wr_stb && addr == `OFF_FLAGS_HI;
wire wr_hit_tick = wr_stb && addr == `OFF_TICK;
always @(posedge sys_clk)
begin
  if (!reset_n)
  begin
    enable_q <= 16'h0000;
    detect_en_q <= 1'b0;
    service_sel_q <= 1'b0;
    tick_rate_select <= 3'h0;
  end
  else if (wr_stb)
  begin
    if (wr_hit_en_lo)
      enable_q[7:0] <= wdata;
    if (wr_hit_en_hi)
      enable_q[15:8] <= wdata;
    if (addr == `OFF_CONTROL)
    begin
      detect_en_q <= wdata[`CTL_DETECT_BIT];
      service_sel_q <= wdata[`CTL_SELECT_BIT];
    end
    if (wr_hit_tick)
      tick_rate_select <= wdata[2:0]; // [RULE17]
  end
end

// ----------------------------------------------------------------
// Source event detection
// ----------------------------------------------------------------
wire idle_limit = uart_long_frame ? (idle_cnt_q == `IDLE_BITS_LONG - 1)
                                  : (idle_cnt_q == `IDLE_BITS - 1);
reg [`NUM_EV-1:0] set_ev;
always @*
begin
  set_ev = 16'h0000;
  set_ev[`EV_ROLL] = timer2_rollover; // [RULE1]
  set_ev[`EV_CH0] = timer2_chan0_event; // [RULE2]
  set_ev[`EV_SRX] = spi_rx_load; // [RULE3]
  set_ev[`EV_STX] = spi_tx_load; // [RULE4]
  set_ev[`EV_SELECT_CONFLICT_FLAG] = detect_en_q &&
    (spi_is_master ? !select_n
                   : (spi_busy && select_n && !select_prev_q)); // [RULE5]
  set_ev[`EV_SOVR] = spi_rx_load && spi_unread_q; // [RULE6]
  set_ev[`EV_UTX] = uart_tx_load; // [RULE7]
  set_ev[`EV_TC] = uart_shift_empty && uart_data_empty &&
    !uart_break_idle_gen; // [RULE8]
  set_ev[`EV_URX] = uart_rx_load; // [RULE9]
  set_ev[`EV_IDLE] = uart_rx_bit_valid && uart_rx_bit && idle_limit; // [RULE10]
  set_ev[`EV_UOVR] = uart_rx_load && uart_unread_q; // [RULE11]
  set_ev[`EV_NOISE] = uart_noise; // [RULE12]
  set_ev[`EV_FRAME] = uart_stop_sample && !uart_stop_bit; // [RULE13]
  set_ev[`EV_PAR] = uart_parity_fail; // [RULE14]
  set_ev[`EV_CONV] = conv_done; // [RULE16]
  set_ev[`EV_TICK] = tick_rollover; // [RULE17]
end

// Idle counter saturates so a long idle line flags once only
always @(posedge sys_clk)
begin
  if (!reset_n)
    idle_cnt_q <= 4'h0;
  else if (uart_rx_bit_valid)
  begin
    if (!uart_rx_bit)
      idle_cnt_q <= 4'h0;
    else if (idle_cnt_q != 4'hF)
      idle_cnt_q <= idle_cnt_q + 4'h1; // [RULE10]
  end
end

// Unread trackers for overflow and overrun detection
always @(posedge sys_clk)
begin
  if (!reset_n)
  begin
    spi_unread_q <= 1'b0;
    uart_unread_q <= 1'b0;
  end
  else
  begin
    if (spi_rx_load)
      spi_unread_q <= 1'b1; // [RULE6]
    else if (spi_data_read)
      spi_unread_q <= 1'b0;
    if (uart_rx_load)
      uart_unread_q <= 1'b1; // [RULE11]
    else if (uart_data_read)
      uart_unread_q <= 1'b0;
  end
end

// ----------------------------------------------------------------
// Sticky flags: set wins over a same-cycle clear
// ----------------------------------------------------------------
wire tick_ack = wr_hit_tick && wdata[`TICK_ACK_BIT];
genvar gi;
generate
  for (gi = 0; gi < `NUM_EV; gi = gi + 1)
  begin : g_flag
    wire clr;
    if (gi < 8)
      assign clr = wr_hit_fl_lo && wdata[gi];
    else if (gi == `EV_TICK)
      assign clr = (wr_hit_fl_hi && wdata[gi - 8]) || tick_ack; // [RULE18]
    else
      assign clr = wr_hit_fl_hi && wdata[gi - 8];
    always @(posedge sys_clk)
    begin
      if (!reset_n)
        flags_q[gi] <= 1'b0;
      else if (set_ev[gi])
        flags_q[gi] <= 1'b1;
      else if (clr)
        flags_q[gi] <= 1'b0;
    end
  end
endgenerate

// Keyboard latch held until the keyboard logic acknowledges it
always @(posedge sys_clk)
begin
  if (!reset_n)
    kbd_latch_q <= 1'b0;
  else if (pin_sync_q[5:1] != 5'h1F)
    kbd_latch_q <= 1'b1; // [RULE15]
  else if (kbd_ack)
    kbd_latch_q <= 1'b0;
end

// ----------------------------------------------------------------
// Request gating and numbered pending flags
// ----------------------------------------------------------------
wire [`NUM_EV-1:0] gated = flags_q & enable_q; // [RULE24]
reg [16:1] pend_d;
reg [16:1] pend_q;
always @*
begin
  pend_d = 16'h0000;
  pend_d[1] = ext_irq_req; // [RULE19]
  pend_d[2] = pll_irq_req;
  pend_d[5:3] = timer1_irq_req;
  pend_d[6] = gated[`EV_CH0]; // [RULE2]
  pend_d[7] = 1'b0;
  pend_d[8] = gated[`EV_ROLL]; // [RULE1]
  pend_d[9] = gated[`EV_SRX] | gated[`EV_SOVR] | gated[`EV_SELECT_CONFLICT_FLAG]; // [RULE24]
  pend_d[10] = gated[`EV_STX];
  pend_d[11] = |gated[`EV_PAR:`EV_UOVR];
  pend_d[12] = gated[`EV_URX] | gated[`EV_IDLE];
  pend_d[13] = gated[`EV_UTX] | gated[`EV_TC];
  pend_d[14] = kbd_latch_q;
  // Service select set means no CPU request; no other servicer exists
  pend_d[15] = gated[`EV_CONV] & !service_sel_q; // [RULE16]
  pend_d[16] = gated[`EV_TICK]; // [RULE17]
end

// Priority pick: lowest flag number wins
reg [4:0] vec_d;
integer k;
always @*
begin
  vec_d = 5'h00;
  for (k = 16; k >= 1; k = k - 1)
    if (pend_d[k])
      vec_d = k[4:0]; // [RULE23]
end

always @(posedge sys_clk)
begin
  if (!reset_n)
  begin
    pend_q <= 16'h0000;
    irq_vector_num <= 5'h00;
    irq_pending <= 1'b0;
  end
  else
  begin
    pend_q <= pend_d;
    irq_vector_num <= vec_d; // [RULE23]
    irq_pending <= |pend_d;
  end
end

// ----------------------------------------------------------------
// Read port; status registers ignore writes
// ----------------------------------------------------------------
reg [7:0] rd_d;
always @*
begin
  case (addr)
    `OFF_PENDING_LOW: rd_d = {pend_q[6:1], 2'b00}; // [RULE20]
    `OFF_PENDING_MID: rd_d = pend_q[14:7]; // [RULE21]
    `OFF_PENDING_HIGH: rd_d = {6'h00, pend_q[16:15]}; // [RULE22]
    `OFF_ENABLE_LO: rd_d = enable_q[7:0];
    `OFF_ENABLE_HI: rd_d = enable_q[15:8];
    `OFF_FLAGS_LO: rd_d = flags_q[7:0];
    `OFF_FLAGS_HI: rd_d = flags_q[15:8];
    `OFF_CONTROL: rd_d = {6'h00, service_sel_q, detect_en_q};
    `OFF_TICK: rd_d = {5'h00, tick_rate_select};
    default: rd_d = 8'h00;
  endcase
end

always @(posedge sys_clk)
begin
  if (!reset_n)
    rdata <= `RESET_BYTE;
  else if (rd_stb)
    rdata <= rd_d;
  else
    rdata <= 8'h00;
end

endmodule // interrupt_source_status

// file: bench/irq_status_checker.sv
// Port assertions for the interrupt status block
`timescale 1ns/1ps
`include "irq_status_map.vh"
// ----------
// Checker
// ----------
module irq_status_checker (
  input wire sys_clk,
  input wire reset_n,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata,
  input wire ext_irq_req,
  input wire [2:0] tick_rate_select,
  input wire [4:0] irq_vector_num,
  input wire irq_pending
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  low_pad_zero_a: assert property (rd_stb && addr == `OFF_PENDING_LOW
    |=> rdata[1:0] == 2'h0) else $error("low status pad bits set");
  high_pad_zero_a: assert property (rd_stb && addr == `OFF_PENDING_HIGH
    |=> rdata[7:2] == 6'h00) else $error("high status pad bits set");
  rdata_idle_a: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data without a read");
  ext_status_a: assert property (ext_irq_req [*3] ##0
    (rd_stb && addr == `OFF_PENDING_LOW) |=> rdata[2])
    else $error("pin request missing from status");
  ext_first_a: assert property (ext_irq_req [*3]
    |-> irq_vector_num == 5'h01) else $error("pin request not first");
  pend_vec_a: assert property (irq_pending == (irq_vector_num != 5'h00))
    else $error("pending and vector disagree");
  vec_range_a: assert property (irq_vector_num != 5'h07
    && irq_vector_num <= 5'h10) else $error("vector out of range");
  rate_load_a: assert property (wr_stb && addr == `OFF_TICK
    |=> {5'h00, tick_rate_select} == ($past(wdata) & 8'h07))
    else $error("rate not loaded");
  rate_hold_a: assert property (!(wr_stb && addr == `OFF_TICK)
    |=> $stable(tick_rate_select)) else $error("rate changed");
endmodule // irq_status_checker

bind interrupt_source_status irq_status_checker chk_u (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .addr(addr),
  .wdata(wdata),
  .wr_stb(wr_stb),
  .rd_stb(rd_stb),
  .rdata(rdata),
  .ext_irq_req(ext_irq_req),
  .tick_rate_select(tick_rate_select),
  .irq_vector_num(irq_vector_num),
  .irq_pending(irq_pending)
);

// file: bench/periph_model.sv
// Peripheral stand-in raising one-cycle event strobes
`timescale 1ns/1ps
// ----------
// Events
// ----------
module periph_model (
  input wire go,
  input wire [3:0] sel,
  output wire [15:0] ev
);
  // One strobe a cycle keeps each flag's cause unambiguous
  assign ev = go ? (16'h0001 << sel) : 16'h0000;
endmodule // periph_model

// file: bench/interrupt_source_status_bench.sv
// Self-checking bench for the interrupt status block
`timescale 1ns/1ps
`include "irq_status_map.vh"
// ----------
// Bench
// ----------
module interrupt_source_status_bench;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [15:0] addr = 16'h0000;
  reg [7:0] wdata = 8'h00;
  reg wr_stb = 1'b0, rd_stb = 1'b0, go = 1'b0, ext = 1'b0, pll = 1'b0;
  reg kack = 1'b0, rbv = 1'b0;
  reg [2:0] t1 = 3'h0;
  reg [3:0] sel = 4'h0;
  reg [4:0] kbd_n = 5'h1F;
  reg [10:0] lv = 11'h000;
  reg [15:0] t;
  reg [159:0] tbl = 160'h0502_1480_2504_3508_6540_8520_B510_D510_E601_F602;
  wire [15:0] ev;
  wire [7:0] rdata;
  wire [2:0] rate;
  wire [4:0] vec;
  wire pend;
  integer i, n_fail = 0, cmp_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  periph_model pm (.go(go), .sel(sel), .ev(ev));
  interrupt_source_status dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .ext_irq_req(ext), .pll_irq_req(pll),
    .timer1_irq_req(t1), .timer2_rollover(ev[0]),
    .timer2_chan0_event(ev[1]), .spi_rx_load(ev[2]), .spi_tx_load(ev[3]),
    .spi_is_master(lv[0]), .spi_busy(lv[1]), .spi_select_n(~lv[2]),
    .spi_data_read(lv[3]), .uart_tx_load(ev[6]), .uart_shift_empty(lv[4]),
    .uart_data_empty(lv[5]), .uart_break_idle_gen(lv[6]),
    .uart_rx_load(ev[8]), .uart_rx_bit_valid(rbv), .uart_rx_bit(1'b1),
    .uart_long_frame(lv[7]), .uart_data_read(lv[8]), .uart_noise(ev[11]),
    .uart_stop_sample(lv[9]), .uart_stop_bit(~lv[10]),
    .uart_parity_fail(ev[13]), .kbd_pins_n(kbd_n), .kbd_ack(kack),
    .conv_done(ev[14]), .tick_rollover(ev[15]), .tick_rate_select(rate),
    .irq_vector_num(vec), .irq_pending(pend));
  task chk(input [7:0] s, input [7:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 chk(rdata, e);
    end
  endtask
  task fire(input [3:0] n);
    begin
      @(posedge sys_clk);
      sel <= n;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
    end
  endtask
  task rx_ones(input integer n);
    begin
      repeat (n)
      begin
        @(posedge sys_clk);
        rbv <= 1'b1;
        @(posedge sys_clk);
        rbv <= 1'b0;
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    n_fail = n_fail + 1;
    close_out;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`OFF_PENDING_LOW, 8'h00);
    rd(`OFF_PENDING_MID, 8'h00);
    rd(`OFF_PENDING_HIGH, 8'h00);
    wr(`OFF_PENDING_LOW, 8'hFF);
    rd(`OFF_PENDING_LOW, 8'h00);
    rd(16'h0000, 8'h00);
    $display("test reset done");
    wr(`OFF_ENABLE_LO, 8'hFF);
    wr(`OFF_ENABLE_HI, 8'hFF);
    for (i = 0; i < 10; i = i + 1)
    begin
      t = tbl[i*16 +: 16];
      fire(t[15:12]);
      rd(16'hFE00 | t[11:8], t[7:0]);
      if (t[15:12] == 4'hF)
        wr(`OFF_TICK, 8'h0D);
      else
        wr(t[15] ? `OFF_FLAGS_HI : `OFF_FLAGS_LO, 8'h01 << t[14:12]);
      rd(16'hFE00 | t[11:8], 8'h00);
    end
    chk({5'h00, rate}, 8'h05);
    $display("test events done");
    wr(`OFF_ENABLE_LO, 8'hFE);
    fire(4'h0);
    rd(`OFF_PENDING_MID, 8'h00);
    rd(`OFF_FLAGS_LO, 8'h01);
    wr(`OFF_CONTROL, 8'h02);
    fire(4'hE);
    rd(`OFF_PENDING_HIGH, 8'h00);
    wr(`OFF_FLAGS_HI, 8'h40);
    wr(`OFF_CONTROL, 8'h00);
    ext <= 1'b1;
    pll <= 1'b1;
    t1 <= 3'h5;
    rd(`OFF_PENDING_LOW, 8'h5C);
    chk({3'h0, vec}, 8'h01);
    chk({7'h00, pend}, 8'h01);
    wr(`OFF_ENABLE_LO, 8'hFF);
    ext <= 1'b0;
    rd(`OFF_PENDING_LOW, 8'h58);
    chk({3'h0, vec}, 8'h02);
    $display("test gating done");
    wr(`OFF_FLAGS_LO, 8'h01);
    pll <= 1'b0;
    t1 <= 3'h0;
    rx_ones(9);
    rd(`OFF_PENDING_MID, 8'h00);
    rx_ones(1);
    rd(`OFF_PENDING_MID, 8'h20);
    wr(`OFF_FLAGS_HI, 8'h02);
    kbd_n <= 5'h1B;
    rx_ones(2);
    kbd_n <= 5'h1F;
    rd(`OFF_PENDING_MID, 8'h80);
    fire(4'h0);
    kack <= 1'b1;
    fire(4'h1);
    kack <= 1'b0;
    wr(`OFF_FLAGS_LO, 8'h03);
    rd(`OFF_PENDING_MID, 8'h00);
    $display("test pins done");
    fire(4'h2);
    rd(`OFF_PENDING_MID, 8'h04);
    rd(`OFF_FLAGS_LO, 8'h24);
    wr(`OFF_FLAGS_LO, 8'h24);
    lv[3] <= 1'b1;
    fire(4'h2);
    lv[3] <= 1'b0;
    rd(`OFF_FLAGS_LO, 8'h04);
    wr(`OFF_FLAGS_LO, 8'h04);
    lv[5:4] <= 2'h3;
    repeat (2) @(posedge sys_clk);
    rd(`OFF_PENDING_MID, 8'h40);
    rd(`OFF_FLAGS_LO, 8'h80);
    lv[6] <= 1'b1;
    wr(`OFF_FLAGS_LO, 8'h80);
    rd(`OFF_FLAGS_LO, 8'h00);
    lv[6:4] <= 3'h0;
    wr(`OFF_CONTROL, 8'h01);
    lv[0] <= 1'b1;
    lv[2] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    lv[2] <= 1'b0;
    rd(`OFF_PENDING_MID, 8'h04);
    wr(`OFF_FLAGS_LO, 8'h10);
    rd(`OFF_FLAGS_LO, 8'h00);
    lv[0] <= 1'b0;
    wr(`OFF_CONTROL, 8'h00);
    lv[10:9] <= 2'h3;
    @(posedge sys_clk);
    lv[10:9] <= 2'h0;
    rd(`OFF_PENDING_MID, 8'h10);
    rd(`OFF_FLAGS_HI, 8'h10);
    wr(`OFF_FLAGS_HI, 8'h10);
    rd(`OFF_PENDING_MID, 8'h00);
    chk({7'h00, pend}, 8'h00);
    $display("test errors done");
    close_out;
  end
endmodule // interrupt_source_status_bench
